// ---- core/sams_pkg.sv ----
// sams_pkg: constants and types shared by the converter sequencer files.
// assumes a single system clock domain; host pins are synchronised first.
package sams_pkg;
  // multiplexer option: 1, 2, 4 or 8 analog channels
  typedef enum logic [1:0] {OPT_1CH, OPT_2CH, OPT_4CH, OPT_8CH} sams_option_type;

  // apb register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;

  // field positions and reset values
  localparam int CFG_OPT_LSB = 0;
  localparam sams_option_type CFG_OPT_RESET = OPT_8CH;
  localparam int STS_CONV_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_ENABLED_BIT = 2;
  localparam int STS_DRIVE_BIT = 3;
  localparam int RES_POS_LSB = 8;
  localparam int RES_NEG_LSB = 12;

  // channel index used for the shared return input
  localparam logic [3:0] CH_COM = 4'h8;

  // conversion counts
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] LSB_STREAM_FIRST = 4'h1;
  localparam logic [3:0] LSB_STREAM_END = 4'h8;

  // pin synchroniser: {enable_n, conv_clk, cmd_in, lsb_ctl, comp}
  localparam int SYNC_W = 5;
  localparam logic [4:0] SYNC_RESET = 5'h10;

  // address word length in bits for each option
  function automatic logic [2:0] addr_len(input sams_option_type opt);
    unique case (opt)
      OPT_1CH: addr_len = 3'h0;
      OPT_2CH: addr_len = 3'h2;
      OPT_4CH: addr_len = 3'h3;
      OPT_8CH: addr_len = 3'h4;
    endcase
  endfunction
endpackage

// ---- core/sams_sync.sv ----
// sams_sync: two-flop synchroniser for a group of unrelated pin levels.
// assumes each bit is an independent level; no word coherency is implied.
`timescale 1ns/10ps
module sams_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // pin levels in, synchronised levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= RST;
      o_q <= RST;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // sams_sync

// ---- core/sams_mux_decode.sv ----
// sams_mux_decode: turns a received address word into + and - channels.
// assumes the address sits right-aligned in the shift register.
`timescale 1ns/10ps
module sams_mux_decode (
  // address word and option
  input wire sams_pkg::sams_option_type i_option,
  input wire logic [3:0] i_addr,
  // selected channels, CH_COM for the shared return
  output logic [3:0] o_pos,
  output logic [3:0] o_neg
);
  import sams_pkg::*;

  logic single;
  logic odd;
  logic [1:0] pair;

  always_comb begin
    single = 1'h0;
    odd = 1'h0;
    pair = 2'h0;
    unique case (i_option)
      OPT_1CH: begin
        single = 1'h0;
      end
      OPT_2CH: begin
        single = i_addr[1];
        odd = i_addr[0];
      end
      OPT_4CH: begin
        single = i_addr[2];
        odd = i_addr[1];
        pair = {1'h0, i_addr[0]};
      end
      OPT_8CH: begin
        single = i_addr[3];
        odd = i_addr[2];
        pair = i_addr[1:0];
      end
    endcase
    o_pos = {1'h0, pair, odd};
    if (single) begin
      o_neg = CH_COM;
    end else begin
      o_neg = {1'h0, pair, ~odd};
    end
  end
endmodule // sams_mux_decode

// ---- core/sams_sequencer.sv ----
// sams_sequencer: 8-bit successive-approximation sequencer with serial
// host link, channel multiplexer control and an apb configuration slave.
// assumes the host clock, enable and command pins and the comparator
// decision come from outside and are synchronised here; the host clock
// must be far slower than i_sys_clk (each phase several system clocks).
//
// Summary of operation
// - 8ch single-ended: channel 2*pair+odd, return negative
// - 8ch differential: pair chosen, polarity picks positive
// - 4ch word: single, odd, low pair bit
// - 4ch differential: pairs 0-1 or 2-3
// - 2ch: two bits, odd picks channel
// - 2ch differential: polarity swaps channels 0 and 1
// - fresh mux configuration on every conversion
// - sample command input on each rising edge
// - first one is start bit, then address
// - half-period settle after start bit and address placed
// - flag rises, command input ignored afterwards
// - output driven with leading zero after settling
// - decisions shown msb first on falling edges
// - eight periods, flag drops half cycle later
// - result replayed lsb first after msb stream
// - output low after stream until disabled
// - 8ch: shift control high holds lsb
// - single-channel option: msb first only
// - enable high clears all sequencer state but the result copy
// - command sampled only while output released
// - single-channel needs no address word
// - positive below negative gives zero code
`timescale 1ns/10ps
module sams_sequencer (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // host serial link pins
  input wire logic i_conv_clk,
  input wire logic i_device_enable_n,
  input wire logic i_serial_cmd_in,
  input wire logic i_lsb_shift_ctl,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_converting_flag,
  // analog model side
  input wire logic i_comp_hi,
  output logic [7:0] o_trial_code,
  output logic [3:0] o_mux_pos,
  output logic [3:0] o_mux_neg
);
  import sams_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SETTLE, ST_CONV, ST_TAIL, ST_LOW
  } sams_state_type;

  sams_state_type state;
  sams_option_type cfg_opt;
  logic [SYNC_W-1:0] pins_s;
  logic en_n_s, clk_s, cmd_s, lsb_ctl_s, comp_s;
  logic clk_d;
  logic rise, fall;
  logic [2:0] len;
  logic [2:0] addr_cnt;
  logic cnt_last;
  logic go_settle;
  logic [3:0] addr;
  logic [2:0] bit_cnt;
  logic [2:0] bit_idx;
  logic [7:0] next_sar;
  logic [3:0] lsb_idx;
  logic shift_ok;
  logic tail_bit;
  logic [3:0] dec_pos, dec_neg;
  logic [7:0] last_result;
  logic access;
  logic [31:0] rd_data;
  logic rd_err;

  sams_sync #(
    .W(SYNC_W),
    .RST(SYNC_RESET)
  ) u_sync (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_d({i_device_enable_n, i_conv_clk, i_serial_cmd_in, i_lsb_shift_ctl, i_comp_hi}),
    .o_q(pins_s)
  );

  assign {en_n_s, clk_s, cmd_s, lsb_ctl_s, comp_s} = pins_s;

  // host clock edges, seen after synchronisation
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_d <= 1'h0;
    end else begin
      clk_d <= clk_s;
    end
  end

  assign rise = clk_s & ~clk_d;
  assign fall = ~clk_s & clk_d;
  assign len = addr_len(cfg_opt);
  assign cnt_last = (addr_cnt == len - 3'h1);
  assign go_settle = rise && ((state == ST_IDLE && cmd_s && len == 3'h0)
                              || (state == ST_ADDR && cnt_last));
  assign shift_ok = !(cfg_opt == OPT_8CH && lsb_ctl_s);
  assign tail_bit = o_trial_code[lsb_idx[2:0]];

  // sequencer state
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else if (en_n_s) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (rise && cmd_s) begin
            state <= (len == 3'h0) ? ST_SETTLE : ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (go_settle) begin
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (fall) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (fall && bit_cnt == LAST_BIT) begin
            state <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          if (fall && shift_ok && (cfg_opt == OPT_1CH || lsb_idx == LSB_STREAM_END)) begin
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          state <= ST_LOW;
        end
      endcase
    end
  end

  // address shift register and bit counter
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr <= 4'h0;
      addr_cnt <= 3'h0;
    end else if (en_n_s) begin
      addr <= 4'h0;
      addr_cnt <= 3'h0;
    end else if (rise && state == ST_IDLE) begin
      addr <= 4'h0;
      addr_cnt <= 3'h0;
    end else if (rise && state == ST_ADDR) begin
      addr <= {addr[2:0], cmd_s};
      addr_cnt <= addr_cnt + 3'h1;
    end
  end

  sams_mux_decode u_decode (
    .i_option(cfg_opt),
    .i_addr(addr),
    .o_pos(dec_pos),
    .o_neg(dec_neg)
  );

  // channel selection held through the conversion
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mux_pos <= 4'h0;
      o_mux_neg <= 4'h0;
    end else if (en_n_s) begin
      o_mux_pos <= 4'h0;
      o_mux_neg <= 4'h0;
    end else if (state == ST_SETTLE) begin
      o_mux_pos <= dec_pos;
      o_mux_neg <= dec_neg;
    end
  end

  // conversion in progress flag
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_converting_flag <= 1'h0;
    end else if (en_n_s) begin
      o_converting_flag <= 1'h0;
    end else if (go_settle) begin
      o_converting_flag <= 1'h1;
    end else if (rise && (state == ST_TAIL || state == ST_LOW)) begin
      o_converting_flag <= 1'h0;
    end
  end

  // trial bit update for the current decision
  always_comb begin
    bit_idx = LAST_BIT - bit_cnt;
    next_sar = o_trial_code;
    next_sar[bit_idx] = comp_s;
    if (bit_cnt != LAST_BIT) begin
      next_sar[bit_idx - 3'h1] = 1'h1;
    end
  end

  // approximation register; the comparator answers low on every
  // trial when the difference is negative
  // zero code follows
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_trial_code <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (en_n_s) begin
      o_trial_code <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (fall && state == ST_SETTLE) begin
      o_trial_code <= SAR_FIRST_TRIAL;
      bit_cnt <= 3'h0;
    end else if (fall && state == ST_CONV) begin
      o_trial_code <= next_sar;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // lsb-first stream position, bit 0 is shared with the msb stream
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lsb_idx <= LSB_STREAM_FIRST;
    end else if (en_n_s || state == ST_CONV) begin
      lsb_idx <= LSB_STREAM_FIRST;
    end else if (fall && state == ST_TAIL && shift_ok && lsb_idx != LSB_STREAM_END) begin
      lsb_idx <= lsb_idx + 4'h1;
    end
  end

  // serial result pin
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_result_out <= 1'h0;
      o_serial_result_oe <= 1'h0;
    end else if (en_n_s) begin
      o_serial_result_out <= 1'h0;
      o_serial_result_oe <= 1'h0;
    end else if (fall) begin
      unique case (state)
        ST_SETTLE: begin
          o_serial_result_out <= 1'h0;
          o_serial_result_oe <= 1'h1;
        end
        ST_CONV: begin
          o_serial_result_out <= comp_s;
        end
        ST_TAIL: begin
          if (shift_ok) begin
            o_serial_result_out <= (cfg_opt == OPT_1CH || lsb_idx[3]) ? 1'h0 : tail_bit;
          end
        end
        ST_LOW: begin
          o_serial_result_out <= 1'h0;
        end
        default: begin
          o_serial_result_out <= 1'h0;
        end
      endcase
    end
  end

  // result copy for software; kept across enable so it can be read later
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_result <= 8'h00;
    end else if (fall && state == ST_CONV && bit_cnt == LAST_BIT) begin
      last_result <= next_sar;
    end
  end

  // apb: one wait state, answer registered
  assign access = i_psel && i_penable && !o_pready;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'h0;
    case (i_paddr)
      OFS_CFG: begin
        rd_data[CFG_OPT_LSB +: 2] = cfg_opt;
      end
      OFS_STATUS: begin
        rd_data[STS_CONV_BIT] = o_converting_flag;
        rd_data[STS_DONE_BIT] = (state == ST_TAIL || state == ST_LOW);
        rd_data[STS_ENABLED_BIT] = !en_n_s;
        rd_data[STS_DRIVE_BIT] = o_serial_result_oe;
      end
      OFS_RESULT: begin
        rd_data[7:0] = last_result;
        rd_data[RES_POS_LSB +: 4] = o_mux_pos;
        rd_data[RES_NEG_LSB +: 4] = o_mux_neg;
      end
      default: begin
        rd_err = 1'h1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'h0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'h0;
    end else begin
      o_pready <= access;
      o_prdata <= access ? rd_data : 32'h0000_0000;
      o_pslverr <= access && rd_err;
    end
  end

  // option register steers address length and output streams
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_opt <= CFG_OPT_RESET;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFS_CFG) begin
      cfg_opt <= sams_option_type'(i_pwdata[CFG_OPT_LSB +: 2]);
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_addr_shift;
    (!en_n_s && rise && state == ST_ADDR) |=> addr == {$past(addr[2:0]), $past(cmd_s)};
  endproperty
  a_addr_shift: assert property (p_addr_shift) else $error("address shift wrong");

  property p_lead_zero;
    (!en_n_s && rise && state == ST_IDLE && !cmd_s) |=> state == ST_IDLE;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("leading zero started");

  property p_settle;
    (!en_n_s && go_settle) |=> (state == ST_SETTLE && o_converting_flag && !o_serial_result_oe);
  endproperty
  a_settle: assert property (p_settle) else $error("settle entry wrong");

  property p_lead_out;
    (!en_n_s && fall && state == ST_SETTLE) |=> (o_serial_result_oe && !o_serial_result_out);
  endproperty
  a_lead_out: assert property (p_lead_out) else $error("no leading zero");

  property p_msb_bit;
    (!en_n_s && fall && state == ST_CONV) |=> o_serial_result_out == $past(comp_s);
  endproperty
  a_msb_bit: assert property (p_msb_bit) else $error("decision not shown");

  property p_flag_drop;
    (!en_n_s && rise && state == ST_TAIL) |=> !o_converting_flag;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("flag not dropped");

  property p_lsb_replay;
    (!en_n_s && fall && state == ST_TAIL && shift_ok && cfg_opt != OPT_1CH && !lsb_idx[3])
      |=> o_serial_result_out == $past(tail_bit);
  endproperty
  a_lsb_replay: assert property (p_lsb_replay) else $error("lsb stream bit wrong");

  property p_low_end;
    (state == ST_LOW && !en_n_s) |=> (state == ST_LOW || en_n_s) && !o_serial_result_out;
  endproperty
  a_low_end: assert property (p_low_end) else $error("output not low");

  property p_hold_lsb;
    (!en_n_s && state == ST_TAIL && cfg_opt == OPT_8CH && lsb_ctl_s) |=> $stable(o_serial_result_out);
  endproperty
  a_hold_lsb: assert property (p_hold_lsb) else $error("lsb not held");

  property p_msb_only;
    (!en_n_s && fall && state == ST_TAIL && cfg_opt == OPT_1CH) |=> (state == ST_LOW);
  endproperty
  a_msb_only: assert property (p_msb_only) else $error("lsb stream on 1ch");

  property p_clear;
    en_n_s |=> (state == ST_IDLE && !o_serial_result_oe && !o_converting_flag);
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared");

  property p_released;
    (state == ST_IDLE || state == ST_ADDR) |-> !o_serial_result_oe;
  endproperty
  a_released: assert property (p_released) else $error("drive while addressing");

  property p_single_8;
    (!en_n_s && state == ST_SETTLE && cfg_opt == OPT_8CH && addr[3])
      |=> (o_mux_neg == CH_COM && o_mux_pos == {1'h0, addr[1:0], addr[2]});
  endproperty
  a_single_8: assert property (p_single_8) else $error("single mux wrong");

  property p_diff_8;
    (!en_n_s && state == ST_SETTLE && cfg_opt == OPT_8CH && !addr[3])
      |=> (o_mux_pos[0] == $past(addr[2]) && o_mux_neg[0] == !$past(addr[2]));
  endproperty
  a_diff_8: assert property (p_diff_8) else $error("diff polarity wrong");

  property p_first_trial;
    (!en_n_s && fall && state == ST_SETTLE) |=> o_trial_code == SAR_FIRST_TRIAL;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("first trial wrong");
endmodule // sams_sequencer

// ---- verification/sams_host_model.sv ----
// sams_host_model: host end of the serial link plus a behavioural comparator.
// assumes the sequencer pins are wired straight here; one host clock phase is 8 sys clocks.
`timescale 1ns/10ps
module sams_host_model (
  // system clock
  input wire logic i_sys_clk,
  // device outputs
  input wire logic i_serial_result_out,
  input wire logic i_serial_result_oe,
  input wire logic i_converting_flag,
  input wire logic [7:0] i_trial_code,
  // host and analog drives
  output logic o_conv_clk,
  output logic o_device_enable_n,
  output logic o_serial_cmd_in,
  output logic o_lsb_shift_ctl,
  output logic o_comp_hi
);
  logic [7:0] target;
  logic force_low;

  initial begin
    o_conv_clk = 1'b0;
    o_device_enable_n = 1'b1;
    o_serial_cmd_in = 1'b0;
    o_lsb_shift_ctl = 1'b0;
    target = 8'h00;
    force_low = 1'b0;
  end

  assign o_comp_hi = !force_low && (i_trial_code <= target);

  task automatic half;
    repeat (8) @(posedge i_sys_clk);
  endtask

  task automatic convert(input logic [3:0] addr, input int n, input logic ctl, input int stop,
      output logic [17:0] dout, output logic [17:0] flg, output logic ok);
    int i;
    ok = 1'b1;
    dout = '0;
    flg = '0;
    @(posedge i_sys_clk);
    o_lsb_shift_ctl <= ctl;
    // enable low for the whole run
    o_device_enable_n <= 1'b0;
    // leading zeros, start bit, address msb first
    for (i = -3; i < n; i++) begin
      o_serial_cmd_in <= (i < 0) ? (i == -1) : addr[n-1-i];
      half();
      if (i_serial_result_oe !== 1'b0) ok = 1'b0;
      o_conv_clk <= 1'b1;
      half();
      o_conv_clk <= 1'b0;
    end
    // sample just before each rise, where the output has long settled
    for (i = 0; i < 18 && i != stop; i++) begin
      half();
      dout[i] = i_serial_result_out;
      flg[i] = i_converting_flag;
      if (i_serial_result_oe !== 1'b1) ok = 1'b0;
      // host releases the lsb hold after sample 12
      if (i == 12) o_lsb_shift_ctl <= 1'b0;
      o_conv_clk <= 1'b1;
      // shared wire keeps moving; the device must not listen now
      o_serial_cmd_in <= !o_serial_cmd_in;
      half();
      o_conv_clk <= 1'b0;
    end
  endtask

  task automatic finish;
    o_device_enable_n <= 1'b1;
    o_serial_cmd_in <= 1'b0;
    half();
  endtask
endmodule // sams_host_model

// ---- verification/sams_sequencer_tb.sv ----
// sams_sequencer_tb: apb register checks and full conversions on every option.
// assumes the host model drives the link pins and models the comparator.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module sams_sequencer_tb;
  import sams_pkg::*;
  logic i_sys_clk, i_resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic conv_clk, enable_n, cmd, ctl, comp, dout_pin, oe, flag, e, ok;
  logic [7:0] trial;
  logic [3:0] mux_pos, mux_neg;
  logic [17:0] dout, flg;
  int n_fail = 0;
  int checked = 0;
  int lens[4] = '{0, 2, 3, 4};
  int o, a;

  sams_sequencer dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_conv_clk(conv_clk),
    .i_device_enable_n(enable_n), .i_serial_cmd_in(cmd), .i_lsb_shift_ctl(ctl),
    .o_serial_result_out(dout_pin), .o_serial_result_oe(oe), .o_converting_flag(flag),
    .i_comp_hi(comp), .o_trial_code(trial), .o_mux_pos(mux_pos), .o_mux_neg(mux_neg));

  sams_host_model host (.i_sys_clk(i_sys_clk), .i_serial_result_out(dout_pin),
    .i_serial_result_oe(oe), .i_converting_flag(flag), .i_trial_code(trial),
    .o_conv_clk(conv_clk), .o_device_enable_n(enable_n), .o_serial_cmd_in(cmd),
    .o_lsb_shift_ctl(ctl), .o_comp_hi(comp));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int t;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge i_sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    `CHK("pready", 1'b1, pready)
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // stream seen at falls 0..17: leading zero, msb first, then lsb replay;
  // with the hold, lsb stands until the host releases it after sample 12
  function automatic logic [17:0] exp_out(input int op, input logic [7:0] c, input logic sc);
    int k;
    exp_out = '0;
    for (k = 1; k < 9; k++) exp_out[k] = c[8-k];
    for (k = 9; k < 18; k++) begin
      if (op == 3 && sc) exp_out[k] = (k < 13) ? c[0] : c[k-12];
      else if (op != 0 && k < 16) exp_out[k] = c[k-8];
    end
  endfunction

  task automatic run_conv(input int op, input logic [3:0] ad, input logic [7:0] c,
      input logic sc, input logic lo);
    int n;
    logic [1:0] sel;
    logic [7:0] ec;
    n = lens[op];
    sel = (n == 4) ? ad[1:0] : (n == 3) ? {1'b0, ad[0]} : 2'h0;
    ec = lo ? 8'h00 : c;
    host.target = c;
    host.force_low = lo;
    host.convert(ad, n, sc, 18, dout, flg, ok);
    `CHK("stream", exp_out(op, ec, sc), dout)
    `CHK("flag", 18'h001FF, flg)
    `CHK("drive", 1'b1, ok)
    if (op != 0) begin
      `CHK("pos", {1'b0, sel, ad[n-2]}, mux_pos)
      `CHK("neg", ad[n-1] ? CH_COM : {1'b0, sel, !ad[n-2]}, mux_neg)
    end
    apb(1'b0, OFS_RESULT, 32'h0);
    `CHK("result", ec, d[7:0])
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status run", 32'hE, d)
    host.finish();
  endtask

  initial begin
    i_resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg reset", 32'h3, d)
    apb(1'b1, OFS_STATUS, 32'hF);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, d)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, d)
    apb(1'b1, 8'h01, 32'h0);
    `CHK("unaligned err", 1'b1, e)
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg kept", 32'h3, d)
    for (o = 0; o < 4; o++) begin
      apb(1'b1, OFS_CFG, 32'(o));
      apb(1'b0, OFS_CFG, 32'h0);
      `CHK("cfg", 32'(o), d)
      for (a = 0; a < (1 << lens[o]); a++) begin
        run_conv(o, 4'(a), (a == 1) ? 8'hFF : 8'(a * 37 + o * 50), 1'b0, 1'b0);
      end
    end
    run_conv(3, 4'h9, 8'hC4, 1'b1, 1'b0);
    run_conv(3, 4'h3, 8'hFF, 1'b0, 1'b1);
    host.target = 8'h55;
    host.convert(4'hF, 4, 1'b0, 4, dout, flg, ok);
    host.finish();
    `CHK("abort flag", 1'b0, flag)
    `CHK("abort drive", 1'b0, oe)
    `CHK("abort mux", 4'h0, mux_pos)
    `CHK("abort neg", 4'h0, mux_neg)
    `CHK("abort trial", 8'h00, trial)
    run_conv(3, 4'hE, 8'hA7, 1'b0, 1'b0);
    close_out();
  end

  initial begin
    repeat (60000) @(posedge i_sys_clk);
    n_fail++;
    close_out();
  end
endmodule // sams_sequencer_tb
